// [shared/phy_int_aux_pkg.sv]
// Register map, field positions and reset values of the interrupt/aux bank
package phy_int_aux_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8; // Byte address width of the slave
	localparam int DATA_W = 32; // Avalon data width
	localparam int REG_W = 16; // Width of every register in the bank
	localparam int EVT_W = 15; // Event flags, bits 14 down to 0

	// ----------------------------------------------------------------
	// Register indices and byte addresses (index times four)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_EVENT_MASK = 8'h19;
	localparam logic [7:0] IDX_INT_STATUS = 8'h1A;
	localparam logic [7:0] IDX_AUX_CTRL = 8'h1C;
	localparam logic [7:0] IDX_LINK_CFG = 8'h20;
	localparam logic [ADDR_W-1:0] ADR_EVENT_MASK = 8'h64;
	localparam logic [ADDR_W-1:0] ADR_INT_STATUS = 8'h68;
	localparam logic [ADDR_W-1:0] ADR_AUX_CTRL = 8'h70;
	localparam logic [ADDR_W-1:0] ADR_LINK_CFG = 8'h80;

	// ----------------------------------------------------------------
	// Interrupt status / mask bit positions
	// ----------------------------------------------------------------
	localparam int BIT_SUMMARY = 15;
	localparam int BIT_SPEED_CHG = 14;
	localparam int BIT_DUPLEX_CHG = 12;
	localparam int BIT_RESERVED = 6;
	localparam int BIT_DOWNSHIFT = 2;
	localparam int BIT_RX_ERR = 0;

	// ----------------------------------------------------------------
	// Auxiliary register bit positions
	// ----------------------------------------------------------------
	localparam int AUX_NEG_DONE = 15;
	localparam int AUX_NEG_OFF = 14;
	localparam int AUX_XOVER = 13;
	localparam int AUX_CD_SWAP = 12;
	localparam int AUX_TMO_HI = 7;
	localparam int AUX_PS_EN = 6;
	localparam int AUX_DUPLEX = 5;
	localparam int AUX_TMO_LO = 2;

	// ----------------------------------------------------------------
	// Link configuration register fields
	// ----------------------------------------------------------------
	localparam int CFG_NEG_EN = 0;
	localparam int CFG_DS_LO = 1; // Downshift controls, 4 bits
	localparam int CFG_AMS_EN = 5;
	localparam int CFG_FX_MODE = 6;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] TMO_RESET = 2'h1; // Bit 7 low, bit 2 high
	localparam logic [15:0] CFG_RESET = 16'h0001;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [1:0] SPEED_1000 = 2'h2;
	localparam logic [1:0] MEDIA_COPPER = 2'h1;

endpackage

// [design/sticky_flags.sv]
// Bank of sticky event flags with set-over-clear priority
`timescale 1ns/1ps
module sticky_flags #(
	parameter int WIDTH = 15
) (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clear_in,
	output logic [WIDTH-1:0] flags_out
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (WIDTH < 1) begin : g_bad_width
		$error("sticky_flags needs at least one flag");
	end

	logic [WIDTH-1:0] flags_r; // Latched flags
	logic [WIDTH-1:0] flags_nxt; // Next value

	// Set wins: an event landing on the clearing edge survives
	assign flags_nxt = (flags_r & ~clear_in) | set_in;

	// Flag storage
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign flags_out = flags_r;

endmodule

// [design/avalon_wait_slave.sv]
// Avalon-MM handshake: one wait state, then the request is accepted
`timescale 1ns/1ps
module avalon_wait_slave (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic read_in,
	input wire logic write_in,
	output logic waitrequest_out,
	output logic capture_out,
	output logic accept_out
);

	// ----------------------------------------------------------------
	// Handshake state
	// ----------------------------------------------------------------
	typedef enum logic {ST_IDLE, ST_ANSWER} hs_state_type;

	hs_state_type state_r; // Current state
	hs_state_type state_nxt; // Next state
	logic req; // Any request present

	assign req = read_in | write_in;

	// Next state: a request always gets exactly one wait cycle
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (req) begin
					state_nxt = ST_ANSWER;
				end
			end
			ST_ANSWER: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Wait is released only in the answer cycle
	assign waitrequest_out = req & (state_r != ST_ANSWER);
	// Read data is sampled in the wait cycle so it stands when accepted
	assign capture_out = read_in & (state_r == ST_IDLE);
	assign accept_out = req & (state_r == ST_ANSWER);

endmodule

// [design/phy_interrupt_aux_status.sv]
// Interrupt status and auxiliary control/status bank with Avalon slave
//
// Notes on behaviour
// RQ1: Bit 15 summarises pending; bits 14:0 give cause.
// RQ2: Reading status clears every returned set bit.
// RQ3: Fourteen event flags latch, bit 6 reserved zero.
// RQ4: Speed and duplex flags need negotiation enabled.
// RQ5: Downshift flag needs all four downshift controls.
// RQ6: Carrier-extension receive errors raise no flag.
// RQ7: Flags pollable and mask writable without pin.
// RQ8: Aux 15 negotiation done, else link status.
// RQ9: Aux 14 negotiation off, or media sense FX.
// RQ10: Aux 13 crossover done, aux 12 pair swap.
// RQ11: Aux 11:8 polarity inversion on pairs A-D.
// RQ12: Sticky two-bit sleep time-out at bits 7,2.
// RQ13: Aux 6 sticky power-save link enable.
// RQ14: Aux 4:3 report resolved speed.
// RQ15: Aux 1:0 report selected media.
// RQ16: Gigabit copper crossover frozen until renegotiation.
// RQ17: Pin follows summary while pin enable set.
// RQ18: Software reads status before enabling pin.
// RQ19: Summary set by any unmasked latched flag.
// RQ20: Aux 5 reports full or half duplex.
// RQ21: Event during read-clear stays latched.
`timescale 1ns/1ps
module phy_interrupt_aux_status
	import phy_int_aux_pkg::*;
(
	input wire logic clock_in,
	input wire logic srst_in,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [3:0] byteenable_in,
	input wire logic [DATA_W-1:0] writedata_in,
	output logic [DATA_W-1:0] readdata_out,
	output logic waitrequest_out,
	// Event strobes, one cycle each
	input wire logic [EVT_W-1:0] event_in,
	input wire logic carrier_extension_in,
	// Resolved link state
	input wire logic neg_complete_in,
	input wire logic link_up_in,
	input wire logic crossover_in,
	input wire logic cd_pair_swap_in,
	input wire logic [3:0] polarity_inv_in,
	input wire logic full_duplex_in,
	input wire logic [1:0] speed_in,
	input wire logic [1:0] media_in,
	// Outputs to the rest of the device
	output logic management_interrupt_pin_out,
	output logic link_sleep_power_save_out,
	output logic [1:0] link_sleep_timeout_out,
	output logic neg_enable_out
);

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	logic capture; // Wait cycle of a read
	logic accept; // Edge at which the request completes

	avalon_wait_slave u_hs (
		.clock_in(clock_in),
		.srst_in(srst_in),
		.read_in(read_in),
		.write_in(write_in),
		.waitrequest_out(waitrequest_out),
		.capture_out(capture),
		.accept_out(accept)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire sel_mask = (address_in == ADR_EVENT_MASK); // Mask register
	wire sel_status = (address_in == ADR_INT_STATUS); // Status register
	wire sel_aux = (address_in == ADR_AUX_CTRL); // Aux register
	wire sel_cfg = (address_in == ADR_LINK_CFG); // Link config
	wire wr_go = accept & write_in; // Write takes effect here
	wire rd_done = accept & read_in & sel_status; // Read-clear moment

	// ----------------------------------------------------------------
	// Software-written registers
	// ----------------------------------------------------------------
	logic [REG_W-1:0] mask_r; // Event mask, bit 15 pin enable
	logic [REG_W-1:0] mask_nxt;
	logic [REG_W-1:0] cfg_r; // Link configuration
	logic [REG_W-1:0] cfg_nxt;
	logic [1:0] tmo_r; // Sleep time-out code, {bit7, bit2}
	logic [1:0] tmo_nxt;
	logic ps_en_r; // Power-save link enable
	logic ps_en_nxt;

	// Byte-lane merge of write data into the mask and config registers
	wire [REG_W-1:0] lane_mask = {{8{byteenable_in[1]}},
		{8{byteenable_in[0]}}};
	wire [REG_W-1:0] wdata = writedata_in[REG_W-1:0];

	// Mask stays writable whether or not the pin is used [RQ7]
	assign mask_nxt = (wr_go & sel_mask) ?
		((mask_r & ~lane_mask) | (wdata & lane_mask)) : mask_r;
	assign cfg_nxt = (wr_go & sel_cfg) ?
		((cfg_r & ~lane_mask) | (wdata & lane_mask)) : cfg_r;

	// Aux control fields live in the low byte only
	wire aux_wr = wr_go & sel_aux & byteenable_in[0];
	// Time-out code as written, MSB from bit 7
	wire [1:0] tmo_wr_code = {wdata[AUX_TMO_HI], wdata[AUX_TMO_LO]};
	assign tmo_nxt = aux_wr ? tmo_wr_code : tmo_r; // [RQ12]
	assign ps_en_nxt = aux_wr ? wdata[AUX_PS_EN] : ps_en_r; // [RQ13]

	// Control storage; synchronous reset loads the package reset values
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			mask_r <= MASK_RESET;
			cfg_r <= CFG_RESET;
			tmo_r <= TMO_RESET;
			ps_en_r <= 1'b0;
		end else begin
			mask_r <= mask_nxt;
			cfg_r <= cfg_nxt;
			tmo_r <= tmo_nxt;
			ps_en_r <= ps_en_nxt;
		end
	end

	// Config fields
	wire neg_en = cfg_r[CFG_NEG_EN]; // Autonegotiation enable
	wire ds_all = &cfg_r[CFG_DS_LO +: 4]; // All downshift controls
	wire ams_fx = cfg_r[CFG_AMS_EN] & cfg_r[CFG_FX_MODE];

	// ----------------------------------------------------------------
	// Event qualification
	// ----------------------------------------------------------------
	logic [EVT_W-1:0] set_vec; // Qualified event strobes
	logic [EVT_W-1:0] clr_vec; // Bits returned by the last read
	logic [EVT_W-1:0] flags; // Latched event flags
	logic [DATA_W-1:0] readdata_r; // Captured read word

	// Gate each strobe by its documented precondition
	always_comb begin
		set_vec = event_in; // [RQ3]
		set_vec[BIT_RESERVED] = 1'b0; // [RQ3]
		set_vec[BIT_SPEED_CHG] = event_in[BIT_SPEED_CHG] & neg_en; // [RQ4]
		set_vec[BIT_DUPLEX_CHG] = event_in[BIT_DUPLEX_CHG] & neg_en; // [RQ4]
		set_vec[BIT_DOWNSHIFT] = event_in[BIT_DOWNSHIFT] & ds_all; // [RQ5]
		// Receive errors that carry carrier extension are not errors
		set_vec[BIT_RX_ERR] = event_in[BIT_RX_ERR] &
			~carrier_extension_in; // [RQ6]
	end

	// Clear only what the read returned, so a bit set after capture
	// survives to the next read
	assign clr_vec = rd_done ? readdata_r[EVT_W-1:0] : '0; // [RQ2]

	sticky_flags #(
		.WIDTH(EVT_W)
	) u_flags (
		.clock_in(clock_in),
		.srst_in(srst_in),
		.set_in(set_vec),
		.clear_in(clr_vec), // Set wins over clear [RQ21]
		.flags_out(flags)
	);

	// ----------------------------------------------------------------
	// Summary and interrupt pin
	// ----------------------------------------------------------------
	// Summary derives from flags, so it falls with the read-clear
	wire summary = |(flags & mask_r[EVT_W-1:0]); // [RQ19]
	logic pin_r; // Registered interrupt pin
	logic pin_nxt;

	// Pin enable only blocks assertion; flags keep latching regardless
	assign pin_nxt = mask_r[BIT_SUMMARY] & summary; // [RQ17]

	// Pin register
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			pin_r <= 1'b0;
		end else begin
			pin_r <= pin_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Crossover indication
	// ----------------------------------------------------------------
	logic xover_r; // Reported crossover state
	logic xover_nxt;
	// Gigabit copper with link up holds the last negotiated value
	wire xover_hold = link_up_in & (speed_in == SPEED_1000) &
		(media_in == MEDIA_COPPER);

	assign xover_nxt = xover_hold ? xover_r : crossover_in; // [RQ16]

	// Crossover register; a link drop is the renegotiation point
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			xover_r <= 1'b0;
		end else begin
			xover_r <= xover_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read word assembly
	// ----------------------------------------------------------------
	wire [REG_W-1:0] status_word = {summary, flags}; // [RQ1]
	wire [REG_W-1:0] aux_word = {
		neg_en ? neg_complete_in : link_up_in, // [RQ8]
		~neg_en | ams_fx, // [RQ9]
		xover_r, // [RQ10]
		cd_pair_swap_in, // [RQ10]
		polarity_inv_in[0], polarity_inv_in[1], // [RQ11]
		polarity_inv_in[2], polarity_inv_in[3], // [RQ11]
		tmo_r[1], // [RQ12]
		ps_en_r, // [RQ13]
		full_duplex_in, // [RQ20]
		speed_in, // [RQ14]
		tmo_r[0], // [RQ12]
		media_in // [RQ15]
	};
	// Unmapped addresses read as zero
	wire [REG_W-1:0] rd_word = sel_status ? status_word :
		sel_aux ? aux_word :
		sel_mask ? mask_r :
		sel_cfg ? cfg_r : 16'h0000;

	// Capture in the wait cycle; holds until the next read
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			readdata_r <= 32'h00000000;
		end else if (capture) begin
			readdata_r <= {16'h0000, rd_word};
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign readdata_out = readdata_r;
	assign management_interrupt_pin_out = pin_r;
	assign link_sleep_power_save_out = ps_en_r;
	assign link_sleep_timeout_out = tmo_r;
	assign neg_enable_out = neg_en;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_summary;
		@(posedge clock_in) disable iff (srst_in)
		(capture && sel_status) |=> readdata_out[BIT_SUMMARY] ==
			$past(summary);
	endproperty
	a_summary: assert property (p_summary) // [RQ1]
		else $error("summary bit wrong in status read");

	property p_read_clear;
		@(posedge clock_in) disable iff (srst_in)
		rd_done |=> (flags & $past(clr_vec) & ~$past(set_vec)) == '0;
	endproperty
	a_read_clear: assert property (p_read_clear) // [RQ2]
		else $error("returned flag not cleared by read");

	property p_event_latch;
		@(posedge clock_in) disable iff (srst_in)
		event_in[13] |=> flags[13] [*1] ##0 !flags[BIT_RESERVED];
	endproperty
	a_event_latch: assert property (p_event_latch) // [RQ3]
		else $error("link change event not latched");

	property p_speed_gate;
		@(posedge clock_in) disable iff (srst_in)
		(!neg_en && !flags[BIT_SPEED_CHG]) |=> !flags[BIT_SPEED_CHG];
	endproperty
	a_speed_gate: assert property (p_speed_gate) // [RQ4]
		else $error("speed flag set with negotiation off");

	property p_ds_gate;
		@(posedge clock_in) disable iff (srst_in)
		(!ds_all && !flags[BIT_DOWNSHIFT]) |=> !flags[BIT_DOWNSHIFT];
	endproperty
	a_ds_gate: assert property (p_ds_gate) // [RQ5]
		else $error("downshift flag set without controls");

	property p_rx_ext;
		@(posedge clock_in) disable iff (srst_in)
		(carrier_extension_in && !flags[BIT_RX_ERR]) |=>
			!flags[BIT_RX_ERR];
	endproperty
	a_rx_ext: assert property (p_rx_ext) // [RQ6]
		else $error("carrier extension raised receive error");

	property p_aux_done;
		@(posedge clock_in) disable iff (srst_in)
		(capture && sel_aux) |=> readdata_out[AUX_NEG_DONE] ==
			($past(neg_en) ? $past(neg_complete_in) : $past(link_up_in));
	endproperty
	a_aux_done: assert property (p_aux_done) // [RQ8]
		else $error("aux bit 15 wrong");

	property p_pin;
		@(posedge clock_in) disable iff (srst_in)
		1'b1 |=> management_interrupt_pin_out == $past(pin_nxt);
	endproperty
	a_pin: assert property (p_pin) // [RQ17]
		else $error("interrupt pin does not follow summary");

	property p_xover_hold;
		@(posedge clock_in) disable iff (srst_in)
		xover_hold |=> $stable(xover_r);
	endproperty
	a_xover_hold: assert property (p_xover_hold) // [RQ16]
		else $error("crossover changed with gigabit link up");

	property p_tmo_write;
		@(posedge clock_in) disable iff (srst_in)
		aux_wr |=> link_sleep_timeout_out == $past(tmo_wr_code);
	endproperty
	a_tmo_write: assert property (p_tmo_write) // [RQ12]
		else $error("time-out field not written");

	property p_no_loss;
		@(posedge clock_in) disable iff (srst_in)
		(rd_done && event_in[10]) |=> flags[10];
	endproperty
	a_no_loss: assert property (p_no_loss) // [RQ21]
		else $error("event lost during read-clear");

	property p_wait_one;
		@(posedge clock_in) disable iff (srst_in)
		$rose(read_in) |-> waitrequest_out ##1 !waitrequest_out;
	endproperty
	a_wait_one: assert property (p_wait_one) // One wait state before a read is answered
		else $error("read not answered after one wait");

	// Main scenarios
	c_pending_read: cover property (@(posedge clock_in)
		rd_done && readdata_r[BIT_SUMMARY]);
	c_set_on_clear: cover property (@(posedge clock_in)
		rd_done && |(set_vec & readdata_r[EVT_W-1:0]));
	c_xover_frozen: cover property (@(posedge clock_in)
		xover_hold && (crossover_in != xover_r));
	c_pin_high: cover property (@(posedge clock_in)
		management_interrupt_pin_out);

endmodule

// [test/test_phy_interrupt_aux_status.sv]
// Self-checking bench for the interrupt status and auxiliary register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_phy_interrupt_aux_status;
	import phy_int_aux_pkg::*;

	// ----------------------------------------------------------------
	// Design signals, inputs given a value at time zero
	// ----------------------------------------------------------------
	logic clock_in = 1'b0;
	logic srst_in = 1'b1;
	logic [ADDR_W-1:0] address_in = 8'h00;
	logic read_in = 1'b0;
	logic write_in = 1'b0;
	logic [3:0] byteenable_in = 4'h0;
	logic [DATA_W-1:0] writedata_in = 32'h0;
	logic [DATA_W-1:0] readdata_out;
	logic waitrequest_out;
	logic [EVT_W-1:0] event_in = 15'h0;
	logic carrier_extension_in = 1'b0;
	logic neg_complete_in = 1'b0;
	logic link_up_in = 1'b0;
	logic crossover_in = 1'b0;
	logic cd_pair_swap_in = 1'b0;
	logic [3:0] polarity_inv_in = 4'h0;
	logic full_duplex_in = 1'b0;
	logic [1:0] speed_in = 2'h0;
	logic [1:0] media_in = 2'h0;
	logic pin_out;
	logic power_save_out;
	logic [1:0] timeout_out;
	logic neg_en_out;

	// ----------------------------------------------------------------
	// Reference model state
	// ----------------------------------------------------------------
	logic [14:0] flags_m; // Latched event flags
	logic [15:0] mask_m; // Pin enable and event mask
	logic [15:0] cfg_m; // Link configuration
	logic [2:0] auxw_m; // Writable aux bits {7,6,2}
	logic xover_m; // Crossover as software should see it
	int fails = 0;
	int n_checks = 0;

	phy_interrupt_aux_status uut (
		.clock_in(clock_in), .srst_in(srst_in), .address_in(address_in),
		.read_in(read_in), .write_in(write_in),
		.byteenable_in(byteenable_in), .writedata_in(writedata_in),
		.readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
		.event_in(event_in), .carrier_extension_in(carrier_extension_in),
		.neg_complete_in(neg_complete_in), .link_up_in(link_up_in),
		.crossover_in(crossover_in), .cd_pair_swap_in(cd_pair_swap_in),
		.polarity_inv_in(polarity_inv_in), .full_duplex_in(full_duplex_in),
		.speed_in(speed_in), .media_in(media_in),
		.management_interrupt_pin_out(pin_out),
		.link_sleep_power_save_out(power_save_out),
		.link_sleep_timeout_out(timeout_out), .neg_enable_out(neg_en_out)
	);

	// 100 ns period clock
	always #50 clock_in = ~clock_in;

	// ----------------------------------------------------------------
	// Model helpers
	// ----------------------------------------------------------------
	// Events that are allowed to latch under the present configuration
	function automatic logic [14:0] filt(input logic [14:0] ev);
		filt = ev;
		filt[6] = 1'b0; // Reserved position never latches
		if (!cfg_m[0]) begin
			filt[14] = 1'b0;
			filt[12] = 1'b0;
		end
		if (cfg_m[4:1] !== 4'hF) filt[2] = 1'b0;
		if (carrier_extension_in) filt[0] = 1'b0;
	endfunction

	// Expected auxiliary register word
	function automatic logic [31:0] aux_exp();
		aux_exp = {16'h0, cfg_m[0] ? neg_complete_in : link_up_in,
			!cfg_m[0] | (cfg_m[5] & cfg_m[6]), xover_m, cd_pair_swap_in,
			polarity_inv_in[0], polarity_inv_in[1], polarity_inv_in[2],
			polarity_inv_in[3], auxw_m[2], auxw_m[1], full_duplex_in,
			speed_in, auxw_m[0], media_in};
	endfunction

	// ----------------------------------------------------------------
	// Avalon master: hold the request until waitrequest is seen low
	// ----------------------------------------------------------------
	task automatic bus_op(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd);
		@(posedge clock_in);
		address_in <= a;
		writedata_in <= wd;
		byteenable_in <= be;
		read_in <= !wr;
		write_in <= wr;
		// No cycle count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge clock_in);
		end while (waitrequest_out !== 1'b0);
		rd = readdata_out;
		read_in <= 1'b0;
		write_in <= 1'b0;
	endtask

	// Write and mirror the effect in the model
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] unused;
		bus_op(1'b1, a, d, be, unused);
		if (a == ADR_EVENT_MASK && be[0]) mask_m[7:0] = d[7:0];
		if (a == ADR_EVENT_MASK && be[1]) mask_m[15:8] = d[15:8];
		if (a == ADR_LINK_CFG && be[0]) cfg_m[7:0] = d[7:0];
		if (a == ADR_LINK_CFG && be[1]) cfg_m[15:8] = d[15:8];
		if (a == ADR_AUX_CTRL && be[0]) auxw_m = {d[7], d[6], d[2]};
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus_op(1'b0, a, 32'h0, 4'hF, rd);
		`CHK(rd, exp)
	endtask

	// Status read with an event landing on the clearing edge
	task automatic rd_stat(input logic [14:0] ev);
		logic [31:0] rd;
		logic [31:0] ex;
		ex = {16'h0, |(flags_m & mask_m[14:0]), flags_m};
		fork
			bus_op(1'b0, ADR_INT_STATUS, 32'h0, 4'hF, rd);
			begin
				repeat (2) @(posedge clock_in);
				event_in <= ev;
				@(posedge clock_in);
				event_in <= 15'h0;
			end
		join
		`CHK(rd, ex)
		flags_m = (flags_m & ~ex[14:0]) | filt(ev);
	endtask

	// One-cycle event strobe
	task automatic pulse(input logic [14:0] ev, input logic ce);
		@(posedge clock_in);
		event_in <= ev;
		carrier_extension_in <= ce;
		@(posedge clock_in);
		event_in <= 15'h0;
		flags_m = flags_m | filt(ev);
	endtask

	// New resolved link state; crossover frozen on gigabit copper link
	task automatic set_link();
		logic lk;
		logic xo;
		logic [1:0] sp;
		logic [1:0] md;
		lk = 1'($urandom % 2);
		xo = 1'($urandom % 2);
		sp = 2'($urandom % 3);
		md = 2'($urandom % 3);
		@(posedge clock_in);
		link_up_in <= lk;
		crossover_in <= xo;
		speed_in <= sp;
		media_in <= md;
		neg_complete_in <= 1'($urandom);
		cd_pair_swap_in <= 1'($urandom);
		polarity_inv_in <= 4'($urandom);
		full_duplex_in <= 1'($urandom);
		if (!(lk && sp == SPEED_1000 && md == MEDIA_COPPER)) xover_m = xo;
		repeat (3) @(posedge clock_in);
	endtask

	// ----------------------------------------------------------------
	// Verdict, reached from the main sequence or the watchdog
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog: the run needs about 1330 cycles, under a seventh of this span
	initial begin
		#1000000;
		fails++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(24036));
		flags_m = 15'h0;
		mask_m = MASK_RESET;
		cfg_m = CFG_RESET;
		auxw_m = 3'h1;
		xover_m = 1'b0;
		repeat (10) @(posedge clock_in);
		srst_in <= 1'b0;
		// Reset values, then an unmapped place
		rd_chk(ADR_INT_STATUS, 32'h0);
		rd_chk(ADR_AUX_CTRL, aux_exp());
		rd_chk(ADR_EVENT_MASK, 32'h0);
		rd_chk(8'h04, 32'h0);
		// Random traffic; bits 4:1 forced now and then to open downshift
		for (int i = 0; i < 80; i++) begin
			if (i % 8 == 0) wr(ADR_LINK_CFG, $urandom | ((i % 16 == 0) ?
				32'h1E : 32'h0), 4'h3);
			if (i % 4 == 0) begin
				// Stale flags are read away before the pin enable moves
				rd_stat(15'h0);
				wr(ADR_EVENT_MASK, $urandom, 4'($urandom));
			end
			if (i % 5 == 0) wr(ADR_AUX_CTRL, $urandom, 4'($urandom));
			set_link();
			pulse(15'($urandom), ($urandom % 4) == 0);
			repeat (2) @(posedge clock_in);
			`CHK(pin_out, mask_m[15] & |(flags_m & mask_m[14:0]))
			`CHK(({power_save_out, timeout_out, neg_en_out}),
				({auxw_m[1], auxw_m[2], auxw_m[0], cfg_m[0]}))
			rd_chk(ADR_AUX_CTRL, aux_exp());
			if (i % 3 == 0) wr(ADR_INT_STATUS, $urandom, 4'hF);
			if (i % 2 == 0) rd_stat(15'($urandom));
			if (i % 10 == 0) rd_chk(ADR_EVENT_MASK, {16'h0, mask_m});
		end
		rd_stat(15'h0);
		end_sim();
	end
endmodule
